// ### verif/encoder_sensor_model.sv
// Behavioural quadrature sensor driving one encoder's pins
module encoder_sensor_model (
  input wire logic i_clk,
  output qep_glue_pkg::encoder_pins_s o_pins
);
  timeunit 1ns;
  timeprecision 1ps;
  initial o_pins = '0;
  // One count step, then hold
  task automatic step(input logic up, input int hold);
    @(posedge i_clk);
    o_pins.quad_input_a <= up ? ~o_pins.quad_input_b : o_pins.quad_input_b;
    o_pins.quad_input_b <= up ? o_pins.quad_input_a : ~o_pins.quad_input_a;
    repeat (hold) @(posedge i_clk);
  endtask
  // Both phases at once, a deliberate fault
  task automatic flip(input int hold);
    @(posedge i_clk);
    o_pins.quad_input_a <= ~o_pins.quad_input_a;
    o_pins.quad_input_b <= ~o_pins.quad_input_b;
    repeat (hold) @(posedge i_clk);
  endtask
  // Index or strobe pulse, equal high and low time
  task automatic pulse(input logic idx, input int len);
    @(posedge i_clk);
    if (idx) o_pins.index_input <= 1'b1;
    else o_pins.strobe_input <= 1'b1;
    repeat (len) @(posedge i_clk);
    o_pins.index_input <= 1'b0;
    o_pins.strobe_input <= 1'b0;
    repeat (len) @(posedge i_clk);
  endtask
endmodule // encoder_sensor_model

// ### verif/qep_glue_checker.sv
// Port-level assertions for the quadrature encoder glue
module qep_glue_checker (
  input wire logic i_clk,
  input wire logic i_reset_n,
  input wire qep_glue_pkg::encoder_pins_s i_enc1_pins,
  input wire logic [1:0] o_encoder_clock_enable,
  input wire logic [1:0] o_phase_error_out,
  input wire logic [1:0] o_compare_sync,
  input wire logic o_trip_input_four_n,
  input wire logic o_s_axi_rvalid,
  input wire logic o_s_axi_arready
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking @(posedge i_clk); endclocking
  default disable iff (!i_reset_n);
  reset_clk_on_a:
    assert property (disable iff (1'b0) !i_reset_n |-> o_encoder_clock_enable == 2'b11)
    else $error("enable not forced in reset");
  release_ce_a:
    assert property ($rose(i_reset_n) |-> o_encoder_clock_enable == 2'b11)
    else $error("enable bits not one after reset");
  gated_err_a:
    assert property ((o_phase_error_out & ~$past(o_phase_error_out) &
      ~$past(o_encoder_clock_enable)) == 2'b00)
    else $error("error set while gated");
  gated_sync_a:
    assert property ((o_compare_sync & ~$past(o_encoder_clock_enable)) == 2'b00)
    else $error("compare pulse while gated");
  err_cause_a:
    assert property ($rose(o_phase_error_out[0]) |->
      $past(i_enc1_pins.quad_input_a, 4) != $past(i_enc1_pins.quad_input_a, 5) &&
      $past(i_enc1_pins.quad_input_b, 4) != $past(i_enc1_pins.quad_input_b, 5))
    else $error("error without joint change");
  trip_idle_a:
    assert property (o_phase_error_out == 2'b00 |=> o_trip_input_four_n)
    else $error("trip without error");
  trip_cause_a:
    assert property (!o_trip_input_four_n |-> $past(o_phase_error_out) != 2'b00)
    else $error("trip low with no prior error");
  sync_pulse_a:
    assert property (o_compare_sync[0] |=> !o_compare_sync[0])
    else $error("compare pulse too long");
  ar_block_a:
    assert property (o_s_axi_rvalid |-> !o_s_axi_arready)
    else $error("read taken while answer pending");
endmodule // qep_glue_checker

bind quadrature_encoder_device_integration qep_glue_checker checker_i (
  .i_clk, .i_reset_n, .i_enc1_pins, .o_encoder_clock_enable, .o_phase_error_out,
  .o_compare_sync, .o_trip_input_four_n, .o_s_axi_rvalid, .o_s_axi_arready
);

// ### verif/testbench.sv
// Self-checking bench for the quadrature encoder glue
module testbench;
  timeunit 1ns;
  timeprecision 1ps;
  logic i_clk, i_reset_n, awvalid, wvalid, bready, arvalid, rready;
  logic awready, wready, bvalid, arready, rvalid, trip_n;
  logic [7:0] awaddr, araddr;
  logic [31:0] wdata, rdata;
  logic [3:0] wstrb;
  logic [1:0] ce, err, cs, bresp, rresp;
  qep_glue_pkg::encoder_pins_s p1, p2;
  int err_count, tests_run, cs_cnt;
  quadrature_encoder_device_integration uut (
    .i_clk, .i_reset_n, .i_enc1_pins(p1), .i_enc2_pins(p2),
    .o_encoder_clock_enable(ce), .o_phase_error_out(err), .o_compare_sync(cs),
    .o_trip_input_four_n(trip_n), .i_s_axi_awvalid(awvalid), .o_s_axi_awready(awready),
    .i_s_axi_awaddr(awaddr), .i_s_axi_wvalid(wvalid), .o_s_axi_wready(wready),
    .i_s_axi_wdata(wdata), .i_s_axi_wstrb(wstrb), .o_s_axi_bvalid(bvalid),
    .i_s_axi_bready(bready), .o_s_axi_bresp(bresp), .i_s_axi_arvalid(arvalid),
    .o_s_axi_arready(arready), .i_s_axi_araddr(araddr), .o_s_axi_rvalid(rvalid),
    .i_s_axi_rready(rready), .o_s_axi_rdata(rdata), .o_s_axi_rresp(rresp));
  encoder_sensor_model s1 (.i_clk, .o_pins(p1));
  encoder_sensor_model s2 (.i_clk, .o_pins(p2));
  initial begin
    i_clk = 1'b0;
    forever #5 i_clk = ~i_clk;
  end
  always @(posedge i_clk) cs_cnt += int'(cs[0] === 1'b1) + int'(cs[1] === 1'b1);
  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    tests_run++;
    if (g !== e) begin
      err_count++;
      $display("MISMATCH %s expected %h seen %h", nm, e, g);
    end
  endtask
  task automatic idle(input int n);
    repeat (n) @(posedge i_clk);
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] er);
    @(posedge i_clk);
    awvalid <= 1'b1;
    awaddr <= a;
    wvalid <= 1'b1;
    wdata <= d;
    bready <= 1'b1;
    do begin
      @(posedge i_clk);
      if (awvalid && awready) awvalid <= 1'b0;
      if (wvalid && wready) wvalid <= 1'b0;
    end while (bvalid !== 1'b1);
    bready <= 1'b0;
    chk("bresp", er, bresp);
  endtask
  task automatic rd(input logic [7:0] a, input logic [31:0] e, input logic [1:0] er);
    @(posedge i_clk);
    arvalid <= 1'b1;
    araddr <= a;
    rready <= 1'b1;
    do begin
      @(posedge i_clk);
      if (arvalid && arready) arvalid <= 1'b0;
    end while (rvalid !== 1'b1);
    rready <= 1'b0;
    chk("rdata", e, rdata);
    chk("rresp", er, rresp);
  endtask
  task automatic t_regs;
    rd(qep_glue_pkg::CLK_GATE_OFS, qep_glue_pkg::CLK_GATE_RST, 2'h0);
    rd(8'h3c, 32'h0, qep_glue_pkg::RESP_SLVERR);
    wr(8'h3c, 32'h1, qep_glue_pkg::RESP_SLVERR);
    wstrb <= 4'h1;
    wr(qep_glue_pkg::CMP_OFS, 32'hffff_ffff, 2'h0);
    wstrb <= 4'hf;
    rd(qep_glue_pkg::CMP_OFS, 32'h0000_00ff, 2'h0);
    $display("test regs done");
  endtask
  task automatic t_count;
    wr(qep_glue_pkg::CMP_OFS, 32'h0001_0003, 2'h0);
    repeat (2) s1.step(1'b1, 2);
    s1.step(1'b1, 6);
    chk("compare pulses", 1, cs_cnt);
    rd(qep_glue_pkg::POS1_OFS, 32'h3, 2'h0);
    s1.step(1'b0, 4);
    rd(qep_glue_pkg::POS1_OFS, 32'h2, 2'h0);
    $display("test count done");
  endtask
  task automatic t_gate;
    wr(qep_glue_pkg::CLK_GATE_OFS, 32'h0100_0000, 2'h0);
    s1.step(1'b1, 2);
    s1.step(1'b0, 2);
    repeat (2) s1.flip(2);
    s2.step(1'b1, 6);
    chk("compare pulses", 2, cs_cnt);
    rd(qep_glue_pkg::POS1_OFS, 32'h2, 2'h0);
    rd(qep_glue_pkg::POS2_OFS, 32'h1, 2'h0);
    rd(qep_glue_pkg::ERR_STAT_OFS, 32'h0, 2'h0);
    chk("enables", 2'b10, ce);
    wr(qep_glue_pkg::CLK_GATE_OFS, qep_glue_pkg::CLK_GATE_RST, 2'h0);
    $display("test gate done");
  endtask
  task automatic t_trip;
    s1.flip(6);
    chk("phase error out", 2'b01, err);
    rd(qep_glue_pkg::ERR_STAT_OFS, 32'h1, 2'h0);
    for (int s = 0; s < 4; s++) begin
      wr(qep_glue_pkg::TRIP_CFG_OFS, s, 2'h0);
      idle(3);
      chk("trip", (s == 1 || s == 3), trip_n);
    end
    wr(qep_glue_pkg::TRIP_CFG_OFS, 32'h0, 2'h0);
    wr(qep_glue_pkg::ERR_STAT_OFS, 32'h1, 2'h0);
    idle(3);
    chk("trip", 1, trip_n);
    rd(qep_glue_pkg::POS1_OFS, 32'h2, 2'h0);
    $display("test trip done");
  endtask
  task automatic t_filter;
    logic [2:0] codes [2];
    codes = '{qep_glue_pkg::SEL_SYNC, 3'h7};
    s1.pulse(1'b0, 2);
    idle(6);
    rd(qep_glue_pkg::LATCH_OFS, 32'h2, 2'h0);
    wr(qep_glue_pkg::SEL_B_OFS, {29'h0, qep_glue_pkg::SEL_FILT}, 2'h0);
    s1.pulse(1'b1, 5);
    idle(12);
    rd(qep_glue_pkg::POS1_OFS, 32'h2, 2'h0);
    s1.pulse(1'b1, 8);
    idle(12);
    rd(qep_glue_pkg::POS1_OFS, 32'h0, 2'h0);
    foreach (codes[i]) begin
      s1.step(1'b1, 6);
      wr(qep_glue_pkg::SEL_B_OFS, {29'h0, codes[i]}, 2'h0);
      s1.pulse(1'b1, 2);
      idle(6);
      rd(qep_glue_pkg::POS1_OFS, 32'h0, 2'h0);
    end
    $display("test filter done");
  endtask
  task automatic end_of_test;
    $display("comparisons %0d mismatches %0d", tests_run, err_count);
    if (err_count == 0 && tests_run > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask
  initial begin
    {i_reset_n, awvalid, wvalid, bready, arvalid, rready} = '0;
    {awaddr, araddr, wdata} = '0;
    wstrb = 4'hf;
    {err_count, tests_run, cs_cnt} = '0;
    repeat (3) @(posedge i_clk);
    i_reset_n <= 1'b1;
    t_regs;
    t_count;
    t_gate;
    t_trip;
    t_filter;
    end_of_test;
  end
  initial begin
    repeat (20000) @(posedge i_clk);
    err_count++;
    end_of_test;
  end
endmodule // testbench

// ### verilog/encoder_input_conditioner.sv
// Double synchroniser, glitch filter and path select for one encoder input
module encoder_input_conditioner (
  input wire logic i_clk,
  input wire logic i_reset_n,
  input wire logic i_pin,
  input wire logic [qep_glue_pkg::SEL_W-1:0] i_sel,
  output logic o_level
);
  localparam logic [qep_glue_pkg::FILT_CNT_W-1:0] FILT_LAST =
    qep_glue_pkg::FILT_CNT_W'(qep_glue_pkg::FILTER_CYCLES - 1);
  logic sync1_reg;
  logic sync2_reg;
  logic filt_reg;
  logic [qep_glue_pkg::FILT_CNT_W-1:0] cnt_reg;
  logic level_reg;
  wire differs = sync2_reg != filt_reg;
  wire use_filter = i_sel == qep_glue_pkg::SEL_FILT;
  wire level_next = use_filter ? filt_reg : sync2_reg;

  always_ff @(posedge i_clk) begin
    if (!i_reset_n) begin
      sync1_reg <= 1'b0;
      sync2_reg <= 1'b0;
    end else begin
      sync1_reg <= i_pin;
      sync2_reg <= sync1_reg;
    end
  end

  // Change passes once stable for the filter width
  always_ff @(posedge i_clk) begin
    if (!i_reset_n) begin
      filt_reg <= 1'b0;
      cnt_reg <= '0;
    end else if (!differs) begin
      cnt_reg <= '0;
    end else if (cnt_reg == FILT_LAST) begin
      filt_reg <= sync2_reg;
      cnt_reg <= '0;
    end else begin
      cnt_reg <= cnt_reg + 1'b1;
    end
  end

  always_ff @(posedge i_clk) begin
    if (!i_reset_n) begin
      level_reg <= 1'b0;
    end else begin
      level_reg <= level_next;
    end
  end

  assign o_level = level_reg;
endmodule // encoder_input_conditioner

// ### verilog/qep_glue_pkg.sv
// Constants and types shared by the quadrature encoder glue
package qep_glue_pkg;
  localparam int ADDR_W = 8;
  localparam logic [ADDR_W-1:0] CLK_GATE_OFS = 8'h00;
  localparam logic [ADDR_W-1:0] SEL_A_OFS = 8'h04;
  localparam logic [ADDR_W-1:0] SEL_B_OFS = 8'h08;
  localparam logic [ADDR_W-1:0] SEL_C_OFS = 8'h0c;
  localparam logic [ADDR_W-1:0] TRIP_CFG_OFS = 8'h10;
  localparam logic [ADDR_W-1:0] ERR_STAT_OFS = 8'h14;
  localparam logic [ADDR_W-1:0] POS1_OFS = 8'h18;
  localparam logic [ADDR_W-1:0] POS2_OFS = 8'h1c;
  localparam logic [ADDR_W-1:0] CMP_OFS = 8'h20;
  localparam logic [ADDR_W-1:0] LATCH_OFS = 8'h24;
  localparam logic [31:0] CLK_GATE_RST = 32'h0101_0000;
  localparam int ENC1_CE_BIT = 16;
  localparam int ENC2_CE_BIT = 24;
  localparam int SEL_W = 3;
  localparam logic [SEL_W-1:0] SEL_SYNC = 3'h1;
  localparam logic [SEL_W-1:0] SEL_FILT = 3'h2;
  localparam int FLD0 = 0;
  localparam int FLD1 = 8;
  localparam int FLD2 = 16;
  localparam int FLD3 = 24;
  localparam int FILTER_CYCLES = 6;
  localparam int FILT_CNT_W = 3;
  localparam int POS_W = 16;
  localparam logic [1:0] TRIP_ENC1 = 2'h0;
  localparam logic [1:0] TRIP_ENC2 = 2'h1;
  localparam logic [1:0] TRIP_BOTH = 2'h2;
  localparam logic [1:0] TRIP_NONE = 2'h3;
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;
  typedef struct packed {
    logic quad_input_a;
    logic quad_input_b;
    logic index_input;
    logic strobe_input;
  } encoder_pins_s;
endpackage

// ### verilog/quadrature_encoder_device_integration.sv
// Quadrature encoder glue: clock gates, input select, decoders, trip routing, AXI4-Lite registers
module quadrature_encoder_device_integration (
  input wire logic i_clk,
  input wire logic i_reset_n,
  input wire qep_glue_pkg::encoder_pins_s i_enc1_pins,
  input wire qep_glue_pkg::encoder_pins_s i_enc2_pins,
  output logic [1:0] o_encoder_clock_enable,
  output logic [1:0] o_phase_error_out,
  output logic [1:0] o_compare_sync,
  output logic o_trip_input_four_n,
  input wire logic i_s_axi_awvalid,
  output logic o_s_axi_awready,
  input wire logic [qep_glue_pkg::ADDR_W-1:0] i_s_axi_awaddr,
  input wire logic i_s_axi_wvalid,
  output logic o_s_axi_wready,
  input wire logic [31:0] i_s_axi_wdata,
  input wire logic [3:0] i_s_axi_wstrb,
  output logic o_s_axi_bvalid,
  input wire logic i_s_axi_bready,
  output logic [1:0] o_s_axi_bresp,
  input wire logic i_s_axi_arvalid,
  output logic o_s_axi_arready,
  input wire logic [qep_glue_pkg::ADDR_W-1:0] i_s_axi_araddr,
  output logic o_s_axi_rvalid,
  input wire logic i_s_axi_rready,
  output logic [31:0] o_s_axi_rdata,
  output logic [1:0] o_s_axi_rresp
);
  localparam int PW = qep_glue_pkg::POS_W;

  function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] wd,
                                        input logic [3:0] st);
    logic [31:0] r;
    r = old;
    for (int i = 0; i < 4; i++) begin
      if (st[i]) begin
        r[i*8 +: 8] = wd[i*8 +: 8];
      end
    end
    return r;
  endfunction

  function automatic logic mapped(input logic [qep_glue_pkg::ADDR_W-1:0] a);
    logic hit;
    hit = 1'b0;
    case (a)
      qep_glue_pkg::CLK_GATE_OFS,
      qep_glue_pkg::SEL_A_OFS,
      qep_glue_pkg::SEL_B_OFS,
      qep_glue_pkg::SEL_C_OFS,
      qep_glue_pkg::TRIP_CFG_OFS,
      qep_glue_pkg::ERR_STAT_OFS,
      qep_glue_pkg::POS1_OFS,
      qep_glue_pkg::POS2_OFS,
      qep_glue_pkg::CMP_OFS,
      qep_glue_pkg::LATCH_OFS: hit = 1'b1;
      default: hit = 1'b0;
    endcase
    return hit;
  endfunction

  // Trip source pick from the sticky error flags
  function automatic logic trip_pick(input logic [1:0] cfg, input logic [1:0] flags);
    logic pick;
    pick = 1'b0;
    case (cfg)
      qep_glue_pkg::TRIP_ENC1: pick = flags[0];
      qep_glue_pkg::TRIP_ENC2: pick = flags[1];
      qep_glue_pkg::TRIP_BOTH: pick = |flags;
      qep_glue_pkg::TRIP_NONE: pick = 1'b0;
      default: pick = 1'b0;
    endcase
    return pick;
  endfunction

  // Registers
  logic [31:0] clk_gate_reg;
  logic [31:0] sel_a_reg;
  logic [31:0] sel_b_reg;
  logic [31:0] sel_c_reg;
  logic [1:0] trip_cfg_reg;
  logic [31:0] cmp_reg;
  logic [PW-1:0] pos_reg [2];
  logic [PW-1:0] latch_reg [2];
  logic [1:0] err_reg;
  logic [1:0] sync_pulse_reg;
  logic trip_n_reg;
  logic [3:0] prev_reg [2];

  // AXI state
  logic aw_held_reg;
  logic w_held_reg;
  logic [qep_glue_pkg::ADDR_W-1:0] awaddr_reg;
  logic [31:0] wdata_reg;
  logic [3:0] wstrb_reg;
  logic bvalid_reg;
  logic [1:0] bresp_reg;
  logic rvalid_reg;
  logic [31:0] rdata_reg;
  logic [1:0] rresp_reg;
  wire wr_fire = aw_held_reg && w_held_reg && !bvalid_reg;

  // Input conditioning, eight inputs
  wire [3:0] raw_pins [2];
  wire [qep_glue_pkg::SEL_W-1:0] sel_field [8];
  wire [3:0] lvl [2];
  assign raw_pins[0] = i_enc1_pins;
  assign raw_pins[1] = i_enc2_pins;
  // Order per encoder: a, b, index, strobe (struct bit 3 down to 0)
  assign sel_field[0] = sel_a_reg[qep_glue_pkg::FLD2 +: qep_glue_pkg::SEL_W];
  assign sel_field[1] = sel_a_reg[qep_glue_pkg::FLD3 +: qep_glue_pkg::SEL_W];
  assign sel_field[2] = sel_b_reg[qep_glue_pkg::FLD0 +: qep_glue_pkg::SEL_W];
  assign sel_field[3] = sel_b_reg[qep_glue_pkg::FLD1 +: qep_glue_pkg::SEL_W];
  assign sel_field[4] = sel_b_reg[qep_glue_pkg::FLD2 +: qep_glue_pkg::SEL_W];
  assign sel_field[5] = sel_b_reg[qep_glue_pkg::FLD3 +: qep_glue_pkg::SEL_W];
  assign sel_field[6] = sel_c_reg[qep_glue_pkg::FLD0 +: qep_glue_pkg::SEL_W];
  assign sel_field[7] = sel_c_reg[qep_glue_pkg::FLD1 +: qep_glue_pkg::SEL_W];

  for (genvar e = 0; e < 2; e++) begin : g_enc
    for (genvar k = 0; k < 4; k++) begin : g_in
      encoder_input_conditioner u_cond (
        .i_clk(i_clk),
        .i_reset_n(i_reset_n),
        .i_pin(raw_pins[e][3-k]),
        .i_sel(sel_field[e*4+k]),
        .o_level(lvl[e][3-k])
      );
    end
  end

  // Clock gating: reset overrides, then each bit gates its own module
  wire [1:0] gate_bits = {clk_gate_reg[qep_glue_pkg::ENC2_CE_BIT],
                          clk_gate_reg[qep_glue_pkg::ENC1_CE_BIT]};
  assign o_encoder_clock_enable = i_reset_n ? gate_bits : 2'h3;

  // Quadrature decode; signals per encoder
  wire [1:0] chg_a;
  wire [1:0] chg_b;
  wire [1:0] count_up;
  wire [1:0] step;
  wire [1:0] phase_err;
  wire [1:0] index_rise;
  wire [1:0] strobe_rise;
  wire [PW-1:0] pos_next [2];
  wire [PW-1:0] cmp_val [2];
  assign cmp_val[0] = cmp_reg[PW-1:0];
  assign cmp_val[1] = cmp_reg[2*PW-1:PW];

  for (genvar e = 0; e < 2; e++) begin : g_dec
    assign chg_a[e] = lvl[e][3] ^ prev_reg[e][3];
    assign chg_b[e] = lvl[e][2] ^ prev_reg[e][2];
    assign phase_err[e] = chg_a[e] & chg_b[e];
    assign step[e] = chg_a[e] ^ chg_b[e];
    assign count_up[e] = lvl[e][3] ^ prev_reg[e][2];
    assign index_rise[e] = lvl[e][1] & ~prev_reg[e][1];
    assign strobe_rise[e] = lvl[e][0] & ~prev_reg[e][0];
    assign pos_next[e] = index_rise[e] ? '0 :
      !step[e] ? pos_reg[e] :
      count_up[e] ? pos_reg[e] + 1'b1 : pos_reg[e] - 1'b1;

    // Counter moves one edge after the conditioned level
    always_ff @(posedge i_clk) begin
      if (!i_reset_n) begin
        prev_reg[e] <= '0;
        pos_reg[e] <= '0;
        latch_reg[e] <= '0;
        sync_pulse_reg[e] <= 1'b0;
      end else if (o_encoder_clock_enable[e]) begin
        prev_reg[e] <= lvl[e];
        pos_reg[e] <= pos_next[e];
        sync_pulse_reg[e] <= step[e] && pos_next[e] == cmp_val[e];
        if (strobe_rise[e]) begin
          latch_reg[e] <= pos_reg[e];
        end
      end else begin
        sync_pulse_reg[e] <= 1'b0;
      end
    end
  end

  // Phase error flags: sticky, set wins over write-one-to-clear
  wire err_wr = wr_fire && awaddr_reg == qep_glue_pkg::ERR_STAT_OFS && wstrb_reg[0];
  wire [1:0] err_clr = err_wr ? wdata_reg[1:0] : 2'h0;
  wire [1:0] err_next = (phase_err & o_encoder_clock_enable) | (err_reg & ~err_clr);

  // Selection multiplexer toward the trip input
  wire trip_sel = trip_pick(trip_cfg_reg, err_reg);

  always_ff @(posedge i_clk) begin
    if (!i_reset_n) begin
      err_reg <= '0;
      trip_n_reg <= 1'b1;
    end else begin
      err_reg <= err_next;
      trip_n_reg <= ~trip_sel;
    end
  end

  assign o_phase_error_out = err_reg;
  assign o_compare_sync = sync_pulse_reg;
  assign o_trip_input_four_n = trip_n_reg;

  // AXI4-Lite write path
  assign o_s_axi_awready = !aw_held_reg && !bvalid_reg;
  assign o_s_axi_wready = !w_held_reg && !bvalid_reg;
  wire wr_ok = mapped(awaddr_reg);
  wire wr_sel_gate = wr_fire && awaddr_reg == qep_glue_pkg::CLK_GATE_OFS;
  wire wr_sel_a = wr_fire && awaddr_reg == qep_glue_pkg::SEL_A_OFS;
  wire wr_sel_b = wr_fire && awaddr_reg == qep_glue_pkg::SEL_B_OFS;
  wire wr_sel_c = wr_fire && awaddr_reg == qep_glue_pkg::SEL_C_OFS;
  wire wr_trip = wr_fire && awaddr_reg == qep_glue_pkg::TRIP_CFG_OFS && wstrb_reg[0];
  wire wr_cmp = wr_fire && awaddr_reg == qep_glue_pkg::CMP_OFS;

  always_ff @(posedge i_clk) begin
    if (!i_reset_n) begin
      aw_held_reg <= 1'b0;
      w_held_reg <= 1'b0;
      awaddr_reg <= '0;
      wdata_reg <= '0;
      wstrb_reg <= '0;
      bvalid_reg <= 1'b0;
      bresp_reg <= qep_glue_pkg::RESP_OKAY;
    end else begin
      if (i_s_axi_awvalid && o_s_axi_awready) begin
        aw_held_reg <= 1'b1;
        awaddr_reg <= i_s_axi_awaddr;
      end
      if (i_s_axi_wvalid && o_s_axi_wready) begin
        w_held_reg <= 1'b1;
        wdata_reg <= i_s_axi_wdata;
        wstrb_reg <= i_s_axi_wstrb;
      end
      if (wr_fire) begin
        aw_held_reg <= 1'b0;
        w_held_reg <= 1'b0;
        bvalid_reg <= 1'b1;
        bresp_reg <= wr_ok ? qep_glue_pkg::RESP_OKAY : qep_glue_pkg::RESP_SLVERR;
      end else if (bvalid_reg && i_s_axi_bready) begin
        bvalid_reg <= 1'b0;
      end
    end
  end

  always_ff @(posedge i_clk) begin
    if (!i_reset_n) begin
      clk_gate_reg <= qep_glue_pkg::CLK_GATE_RST;
      sel_a_reg <= '0;
      sel_b_reg <= '0;
      sel_c_reg <= '0;
      trip_cfg_reg <= qep_glue_pkg::TRIP_ENC1;
      cmp_reg <= '0;
    end else begin
      if (wr_sel_gate) begin
        clk_gate_reg <= merge(clk_gate_reg, wdata_reg, wstrb_reg);
      end
      if (wr_sel_a) begin
        sel_a_reg <= merge(sel_a_reg, wdata_reg, wstrb_reg);
      end
      if (wr_sel_b) begin
        sel_b_reg <= merge(sel_b_reg, wdata_reg, wstrb_reg);
      end
      if (wr_sel_c) begin
        sel_c_reg <= merge(sel_c_reg, wdata_reg, wstrb_reg);
      end
      if (wr_trip) begin
        trip_cfg_reg <= wdata_reg[1:0];
      end
      if (wr_cmp) begin
        cmp_reg <= merge(cmp_reg, wdata_reg, wstrb_reg);
      end
    end
  end

  assign o_s_axi_bvalid = bvalid_reg;
  assign o_s_axi_bresp = bresp_reg;

  // AXI4-Lite read path
  assign o_s_axi_arready = !rvalid_reg;
  wire rd_take = i_s_axi_arvalid && !rvalid_reg;
  wire [qep_glue_pkg::ADDR_W-1:0] ra = i_s_axi_araddr;
  wire [31:0] rd_mux =
    ra == qep_glue_pkg::CLK_GATE_OFS ? clk_gate_reg :
    ra == qep_glue_pkg::SEL_A_OFS ? sel_a_reg :
    ra == qep_glue_pkg::SEL_B_OFS ? sel_b_reg :
    ra == qep_glue_pkg::SEL_C_OFS ? sel_c_reg :
    ra == qep_glue_pkg::TRIP_CFG_OFS ? {30'h0, trip_cfg_reg} :
    ra == qep_glue_pkg::ERR_STAT_OFS ? {30'h0, err_reg} :
    ra == qep_glue_pkg::POS1_OFS ? {16'h0, pos_reg[0]} :
    ra == qep_glue_pkg::POS2_OFS ? {16'h0, pos_reg[1]} :
    ra == qep_glue_pkg::CMP_OFS ? cmp_reg :
    ra == qep_glue_pkg::LATCH_OFS ? {latch_reg[1], latch_reg[0]} : 32'h0;

  always_ff @(posedge i_clk) begin
    if (!i_reset_n) begin
      rvalid_reg <= 1'b0;
      rdata_reg <= '0;
      rresp_reg <= qep_glue_pkg::RESP_OKAY;
    end else if (rd_take) begin
      rvalid_reg <= 1'b1;
      rdata_reg <= rd_mux;
      rresp_reg <= mapped(ra) ? qep_glue_pkg::RESP_OKAY : qep_glue_pkg::RESP_SLVERR;
    end else if (i_s_axi_rready) begin
      rvalid_reg <= 1'b0;
    end
  end

  assign o_s_axi_rvalid = rvalid_reg;
  assign o_s_axi_rdata = rdata_reg;
  assign o_s_axi_rresp = rresp_reg;
endmodule // quadrature_encoder_device_integration
